//--- design/ptab_table_access.sv
`timescale 1ns/1ns
// Purpose: Executes table read and table write instructions
// Assumes: Sequencer presents opcode with op_valid one cycle per op
// Notes:   Program memory read data is sampled in the same cycle as the request
module ptab_table_access (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Instruction from sequencer
    input  wire logic                      op_valid,
    input  wire logic [15:0]               opcode,
    output logic                           busy,
    output logic                           done,
    // Pointer and latch load from core
    input  wire logic                      ptr_load,
    input  wire logic [ptab_pkg::PTR_W-1:0] ptr_load_val,
    input  wire logic                      latch_load,
    input  wire logic [7:0]                latch_load_val,
    output logic [ptab_pkg::PTR_W-1:0]     table_pointer,
    output logic [7:0]                     table_latch,
    // Program memory read port
    output logic                           pm_rd_en,
    output logic [ptab_pkg::PTR_W-1:0]     pm_addr,
    input  wire logic [7:0]                pm_rd_data,
    // Holding register readout for programmer
    input  wire logic [2:0]                hold_rd_idx,
    output logic [7:0]                     hold_rd_data,
    output logic                           hold_byte_hi,
    // Status flag write enable, never asserted
    output logic                           status_we
);
    typedef struct packed {
        ptab_pkg::ptab_state_t              st;
        logic [ptab_pkg::PTR_W-1:0]         ptr;
        logic [7:0]                         lat;
        logic [ptab_pkg::PTR_W-1:0]         addr;
        logic                               rd_en;
        logic                               done;
        logic                               hi;
    } ptab_ctl_t;
    ptab_ctl_t s_q, s_d;

    ptab_hold_if hold_bus ();

    ptab_hold_mem #(.DEPTH(ptab_pkg::HOLD_N)) u_hold (
        .clk   (clk),
        .reset (reset),
        .hold  (hold_bus)
    );

    logic       is_tbl;
    logic [1:0] pmode;
    logic [ptab_pkg::PTR_W-1:0] acc_ptr;
    logic [ptab_pkg::PTR_W-1:0] post_ptr;

    // Decode the table instruction family and mode field
    assign is_tbl = op_valid && (opcode[15:4] == ptab_pkg::OP_HIGH) &&
                    opcode[3];
    assign pmode  = opcode[1:0];

    // Access address and pointer update by mode
    always_comb begin
        acc_ptr  = s_q.ptr;
        post_ptr = s_q.ptr;
        case (pmode)
            ptab_pkg::MODE_NONE:     post_ptr = s_q.ptr;
            ptab_pkg::MODE_POST_INC: post_ptr = s_q.ptr + 21'h000001;
            ptab_pkg::MODE_POST_DEC: post_ptr = s_q.ptr - 21'h000001;
            ptab_pkg::MODE_PRE_INC: begin
                acc_ptr  = s_q.ptr + 21'h000001;
                post_ptr = acc_ptr;
            end
            default: post_ptr = s_q.ptr;
        endcase
    end

    // Holding register write path; latch read in second cycle
    assign hold_bus.wr_en   = (s_q.st == ptab_pkg::PTAB_WRT2);
    assign hold_bus.wr_idx  = s_q.addr[ptab_pkg::HOLD_AW-1:0];
    assign hold_bus.wr_data = s_q.lat;
    assign hold_bus.rd_idx  = hold_rd_idx;
    assign hold_rd_data     = hold_bus.rd_data;

    // Next state: first cycle decodes, second cycle moves the byte
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        s_d.rd_en = 1'b0;
        if (ptr_load) begin
            s_d.ptr = ptr_load_val;
        end
        if (latch_load) begin
            s_d.lat = latch_load_val;
        end
        case (s_q.st)
            ptab_pkg::PTAB_IDLE: begin
                if (is_tbl) begin
                    s_d.addr = acc_ptr;
                    s_d.ptr  = post_ptr;
                    s_d.hi   = acc_ptr[0];
                    if (opcode[2]) begin
                        s_d.st = ptab_pkg::PTAB_WRT2;
                    end else begin
                        s_d.st    = ptab_pkg::PTAB_READ2;
                        s_d.rd_en = 1'b1;
                    end
                end
            end
            ptab_pkg::PTAB_READ2: begin
                s_d.lat  = pm_rd_data;
                s_d.done = 1'b1;
                s_d.st   = ptab_pkg::PTAB_IDLE;
            end
            ptab_pkg::PTAB_WRT2: begin
                s_d.done = 1'b1;
                s_d.st   = ptab_pkg::PTAB_IDLE;
            end
            default: s_d.st = ptab_pkg::PTAB_IDLE;
        endcase
    end

    // All control state cleared together
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '{st: ptab_pkg::PTAB_IDLE, ptr: ptab_pkg::PTR_RST,
                     lat: ptab_pkg::LATCH_RST, addr: ptab_pkg::PTR_RST,
                     rd_en: 1'b0, done: 1'b0, hi: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs; table ops never touch arithmetic flags
    assign busy          = (s_q.st != ptab_pkg::PTAB_IDLE);
    assign done          = s_q.done;
    assign table_pointer = s_q.ptr;
    assign table_latch   = s_q.lat;
    assign pm_rd_en      = s_q.rd_en;
    assign pm_addr       = s_q.addr;
    assign hold_byte_hi  = s_q.hi;
    assign status_we     = 1'b0;

    // Checks
    property p_read_latch;
        @(posedge clk) disable iff (reset)
        s_q.st == ptab_pkg::PTAB_READ2 |=> table_latch == $past(pm_rd_data);
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("latch bad");

    property p_read_two;
        @(posedge clk) disable iff (reset)
        (s_q.st == ptab_pkg::PTAB_IDLE && is_tbl && !opcode[2])
            |=> pm_rd_en ##1 done;
    endproperty
    a_read_two: assert property (p_read_two) else $error("read len");

    property p_write_two;
        @(posedge clk) disable iff (reset)
        (s_q.st == ptab_pkg::PTAB_IDLE && is_tbl && opcode[2])
            |=> hold_bus.wr_en ##1 (done && !busy);
    endproperty
    a_write_two: assert property (p_write_two) else $error("write len");

    property p_wr_idx;
        @(posedge clk) disable iff (reset)
        hold_bus.wr_en |-> hold_bus.wr_idx == pm_addr[2:0];
    endproperty
    a_wr_idx: assert property (p_wr_idx) else $error("hold index");

    property p_post_inc;
        @(posedge clk) disable iff (reset || ptr_load)
        (s_q.st == ptab_pkg::PTAB_IDLE && is_tbl && pmode == 2'h1)
            |=> table_pointer == $past(table_pointer) + 21'h000001;
    endproperty
    a_post_inc: assert property (p_post_inc) else $error("post inc");

    property p_post_dec;
        @(posedge clk) disable iff (reset || ptr_load)
        (s_q.st == ptab_pkg::PTAB_IDLE && is_tbl && pmode == 2'h2)
            |=> pm_addr == $past(table_pointer) &&
                table_pointer == $past(table_pointer) - 21'h000001;
    endproperty
    a_post_dec: assert property (p_post_dec) else $error("post dec");

    property p_pre_inc;
        @(posedge clk) disable iff (reset || ptr_load)
        (s_q.st == ptab_pkg::PTAB_IDLE && is_tbl && pmode == 2'h3)
            |=> pm_addr == $past(table_pointer) + 21'h000001 &&
                pm_addr == table_pointer &&
                hold_byte_hi == table_pointer[0];
    endproperty
    a_pre_inc: assert property (p_pre_inc) else $error("pre inc");

    property p_flags;
        @(posedge clk) disable iff (reset) busy |-> !status_we;
    endproperty
    a_flags: assert property (p_flags) else $error("flag write");

    // Done is one cycle wide; a stuck done would retire phantom ops
    property p_done_pulse;
        @(posedge clk) disable iff (reset) done |=> !done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done");

    // Plain and post-modify reads fetch at the unmodified pointer
    property p_read_addr;
        @(posedge clk) disable iff (reset)
        (s_q.st == ptab_pkg::PTAB_IDLE && is_tbl && !opcode[2] &&
         pmode != ptab_pkg::MODE_PRE_INC)
            |=> pm_addr == $past(table_pointer) && pm_rd_en;
    endproperty
    a_read_addr: assert property (p_read_addr) else $error("rd addr");

    property p_hold_rd;
        @(posedge clk) disable iff (reset)
        hold_bus.wr_en && hold_rd_idx == hold_bus.wr_idx ##1
            hold_rd_idx == $past(hold_rd_idx)
            |=> hold_rd_data == $past(hold_bus.wr_data, 2);
    endproperty
    a_hold_rd: assert property (p_hold_rd) else $error("hold data");

    c_read: cover property (@(posedge clk) disable iff (reset)
        s_q.st == ptab_pkg::PTAB_READ2);
    c_write: cover property (@(posedge clk) disable iff (reset)
        hold_bus.wr_en);
    c_pre: cover property (@(posedge clk) disable iff (reset)
        is_tbl && pmode == 2'h3 && !busy);
    c_post_dec: cover property (@(posedge clk) disable iff (reset)
        is_tbl && pmode == 2'h2 && !busy);
endmodule

//--- design/ptab_pkg.sv
// Purpose: Constants and types for the program memory table access block
// Assumes: One instruction cycle per clk edge
// Notes:   Opcode prefixes and pointer modes live here
package ptab_pkg;
    localparam int PTR_W       = 21;
    localparam int HOLD_N      = 8;
    localparam int HOLD_AW     = 3;
    localparam logic [PTR_W-1:0] PTR_RST = 21'h000000;
    localparam logic [7:0]       LATCH_RST = 8'h00;
    localparam logic [7:0]       HOLD_RST  = 8'hff;
    localparam logic [11:0]      OP_HIGH   = 12'h000;
    localparam logic [1:0]       PFX_READ  = 2'h2;
    localparam logic [1:0]       PFX_WRITE = 2'h3;
    localparam logic [1:0]       MODE_NONE = 2'h0;
    localparam logic [1:0]       MODE_POST_INC = 2'h1;
    localparam logic [1:0]       MODE_POST_DEC = 2'h2;
    localparam logic [1:0]       MODE_PRE_INC  = 2'h3;

    typedef enum logic [1:0] {
        PTAB_IDLE  = 2'b00,
        PTAB_READ2 = 2'b01,
        PTAB_WRT2  = 2'b10
    } ptab_state_t;
endpackage

//--- design/ptab_hold_if.sv
`timescale 1ns/1ns
// Purpose: Write and read path to the holding register bank
// Assumes: Single clock domain
// Notes:   Write strobe is one cycle
interface ptab_hold_if;
    logic       wr_en;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [2:0] rd_idx;
    logic [7:0] rd_data;
    modport ctrl (output wr_en, output wr_idx, output wr_data,
                  output rd_idx, input rd_data);
    modport mem  (input wr_en, input wr_idx, input wr_data,
                  input rd_idx, output rd_data);
endinterface

//--- design/ptab_hold_mem.sv
`timescale 1ns/1ns
// Purpose: Eight byte holding registers for flash programming data
// Assumes: Reset clears all entries to erased value
// Notes:   Read data registered, one cycle latency
module ptab_hold_mem #(
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Access port
    ptab_hold_if.mem hold
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] ent;
        logic [7:0]            rd;
    } ptab_mem_t;
    ptab_mem_t s_q, s_d;

    // Write selected entry, register read data
    always_comb begin
        s_d = s_q;
        if (hold.wr_en) begin
            s_d.ent[hold.wr_idx] = hold.wr_data;
        end
        s_d.rd = s_q.ent[hold.rd_idx];
    end

    // Erased flash reads as all ones
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '{ent: {DEPTH{ptab_pkg::HOLD_RST}},
                     rd: ptab_pkg::HOLD_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign hold.rd_data = s_q.rd;
endmodule

//--- test/ptab_pm_model.sv
// Purpose: Program memory stand-in for table reads
// Assumes: Contents are a fixed function of the byte address
// Notes:   Released data bus shows the inverse of its last value
`timescale 1ns/1ns
module ptab_pm_model (
    // Clock
    input  wire logic                       clk,
    // Read port
    input  wire logic                       rd_en,
    input  wire logic [ptab_pkg::PTR_W-1:0] addr,
    output logic [7:0]                      rd_data
);
    logic [7:0] last_q = 8'h00;

    // Drive only while read; otherwise toggle so stale data never matches
    assign rd_data = rd_en ? (addr[7:0] ^ addr[15:8] ^ {3'h0, addr[20:16]})
                           : ~last_q;

    // Remember the last driven value
    always @(posedge clk) begin
        last_q <= rd_data;
    end
endmodule

//--- test/program_memory_table_access_tb_top.sv
// Purpose: Self-checking bench for the table access block
// Assumes: Ops spaced two cycles, one at a time
// Notes:   Random pointer, latch and mode from a fixed seed
`timescale 1ns/1ns
module program_memory_table_access_tb_top;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        op_valid = 1'b0;
    logic [15:0] opcode = 16'h0000;
    logic        ptr_load = 1'b0;
    logic [20:0] ptr_load_val = 21'h000000;
    logic        latch_load = 1'b0;
    logic [7:0]  latch_load_val = 8'h00;
    logic [2:0]  hold_rd_idx = 3'h0;
    logic        busy, done, pm_rd_en, hold_byte_hi, status_we;
    logic [20:0] table_pointer, pm_addr, ptr_e;
    logic [7:0]  table_latch, pm_rd_data, hold_rd_data, lat_e;
    logic [7:0]  hold_e [8];
    int          n_fail = 0;
    int          check_count = 0;
    integer      seed = 87;
    logic [31:0] r;

    always #20 clk = ~clk;

    ptab_table_access dut (.clk(clk), .reset(reset), .op_valid(op_valid),
        .opcode(opcode), .busy(busy), .done(done), .ptr_load(ptr_load),
        .ptr_load_val(ptr_load_val), .latch_load(latch_load),
        .latch_load_val(latch_load_val), .table_pointer(table_pointer),
        .table_latch(table_latch), .pm_rd_en(pm_rd_en), .pm_addr(pm_addr),
        .pm_rd_data(pm_rd_data), .hold_rd_idx(hold_rd_idx),
        .hold_rd_data(hold_rd_data), .hold_byte_hi(hold_byte_hi),
        .status_we(status_we));

    ptab_pm_model pm (.clk(clk), .rd_en(pm_rd_en), .addr(pm_addr),
        .rd_data(pm_rd_data));

    // Expected memory byte at an address
    function automatic logic [7:0] mem_f(input logic [20:0] a);
        return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic idle;
        op_valid = 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Core-side load of pointer and latch
    task automatic ld(input logic [20:0] p, input logic [7:0] l);
        ptr_load = 1'b1;
        ptr_load_val = p;
        latch_load = 1'b1;
        latch_load_val = l;
        @(posedge clk);
        #1;
        ptr_load = 1'b0;
        latch_load = 1'b0;
        ptr_e = p;
        lat_e = l;
        chk(table_pointer, ptr_e);
        chk(table_latch, lat_e);
    endtask

    // One table op; when s is set a stray op is offered while busy and must be ignored
    task automatic do_op(input logic wr, input logic [1:0] m, input logic s);
        logic [20:0] acc;
        acc = (m == 2'h3) ? ptr_e + 21'h1 : ptr_e;
        op_valid = 1'b1;
        opcode = {ptab_pkg::OP_HIGH, 1'b1, wr, m};
        @(posedge clk);
        #1;
        op_valid = s;
        opcode = {ptab_pkg::OP_HIGH, 1'b1, ~wr, 2'h1};
        chk(busy, 1'b1);
        chk(pm_rd_en, !wr);
        if (!wr) chk(pm_addr, acc);
        if (m == 2'h1 || m == 2'h3) ptr_e = ptr_e + 21'h1;
        if (m == 2'h2) ptr_e = ptr_e - 21'h1;
        @(posedge clk);
        #1;
        if (!wr) lat_e = mem_f(acc);
        else hold_e[acc[2:0]] = lat_e;
        chk(done, 1'b1);
        chk(busy, 1'b0);
        chk(table_latch, lat_e);
        chk(table_pointer, ptr_e);
        chk(hold_byte_hi, acc[0]);
        chk(status_we, 1'b0);
    endtask

    // Read back all holding registers
    task automatic hold_chk;
        for (int i = 0; i < 8; i++) begin
            hold_rd_idx = i[2:0];
            @(posedge clk);
            #1;
            chk(hold_rd_data, hold_e[i]);
        end
    endtask

    initial begin
        #400000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        foreach (hold_e[i]) hold_e[i] = 8'hff;
        ptr_e = 21'h000000;
        lat_e = 8'h00;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        chk(table_pointer, ptr_e);
        chk(table_latch, lat_e);
        chk(done, 1'b0);
        hold_chk();
        $display("test reset done");
        // Every mode of both kinds, back to back
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            do_op(k[2], k[1:0], r[0]);
        end
        idle();
        $display("test all modes done");
        // Opcodes outside the table family must not start an op
        for (int k = 0; k < 2; k++) begin
            op_valid = 1'b1;
            opcode = k[0] ? 16'h010f : 16'h0007;
            @(posedge clk);
            #1;
            chk(busy, 1'b0);
        end
        idle();
        // Pointer wraps at both ends of the 21-bit range
        ld(21'h1fffff, 8'h3c);
        do_op(1'b0, 2'h3, 1'b1);
        idle();
        ld(21'h000000, 8'hc3);
        do_op(1'b1, 2'h2, 1'b0);
        idle();
        $display("test wrap done");
        // Random pairs of ops
        for (int k = 0; k < 40; k++) begin
            r = $random(seed);
            ld(r[20:0], r[28:21]);
            r = $random(seed);
            do_op(r[0], r[2:1], r[3]);
            do_op(r[4], r[6:5], r[7]);
            idle();
        end
        hold_chk();
        $display("test random done");
        tally_and_finish();
    end
endmodule
